// file: rtl/atimer_pkg.sv
// package: register map, field positions, reset values and widths of the timer control block
package atimer_pkg;
    localparam int CNT_W = 12;                                  // counter width
    localparam logic [CNT_W-1:0] CNT_MAX = 12'hfff;             // maximum count
    localparam logic [7:0] OFS_CAPTURE_LOW = 8'h00;             // captured_count[7:0]
    localparam logic [7:0] OFS_CAPTURE_HIGH = 8'h04;            // captured_count[11:8]
    localparam logic [7:0] OFS_BREAK_EN = 8'h08;                // break_enable_ctl
    localparam logic [7:0] OFS_CTL_STATUS2 = 8'h0c;             // timer_ctl_status_second
    localparam logic [7:0] OFS_BREAK_CTL = 8'h10;               // break_control
    localparam logic [7:0] OFS_CAPTURE_STATUS = 8'h14;          // capture flag, write 1 to clear
    localparam logic [7:0] OFS_RELOAD2 = 8'h18;                 // second_reload_value
    localparam logic [7:0] OFS_OUT_EN = 8'h1c;                  // pwm_output_enable[3:0]
    localparam logic [7:0] OFS_COUNT1 = 8'h20;                  // first_counter readback
    localparam logic [7:0] OFS_COUNT2 = 8'h24;                  // second_counter readback
    // timer_ctl_status_second fields
    localparam int CS_FIRST_DUTY_TRANSFER_EN = 0;
    localparam int CS_SECOND_DUTY_TRANSFER_EN = 1;
    localparam int CS_SEL2 = 2;
    localparam int CS_SECOND_OVERFLOW_FLAG = 3;
    localparam int CS_SECOND_OVERFLOW_IRQ_EN = 4;
    localparam int CS_ICS = 5;
    localparam int CS_FIRST_COUNTER_FORCE_OVERFLOW = 6;
    localparam int CS_SECOND_COUNTER_FORCE_OVERFLOW = 7;
    // break_enable_ctl fields
    localparam int BE_FIRST_COUNTER_BREAK_EN = 0;
    localparam int BE_SECOND_COUNTER_BREAK_EN = 1;
    localparam int BE_USED_W = 2;                               // bits 7:2 reserved
    // break_control fields
    localparam int BC_ACTIVE = 5;                               // break active
    localparam int BC_PATTERN_W = 4;                            // pattern in bits 3:0
    // reset values
    localparam logic [7:0] RST_CTL_STATUS2 = 8'h03;
    localparam logic [7:0] RST_BREAK_EN = 8'h03;
    localparam logic [7:0] RST_BREAK_CTL = 8'h00;
    localparam logic [CNT_W-1:0] RST_CAPTURE = 12'h000;
    localparam logic [CNT_W-1:0] RST_RELOAD2 = 12'h000;
    localparam logic [3:0] RST_OUT_EN = 4'h0;
endpackage

// file: rtl/sync_edge.sv
// two-flop synchroniser with edge detector for a pin input
`timescale 1ns/1ps
`default_nettype none
module sync_edge (
    input wire logic clk,
    input wire logic nrst,
    input wire logic pin,
    output logic level,
    output logic edge_pulse
);
    logic meta_reg; // first stage, read only by the second stage
    logic sync_reg; // second stage
    logic last_reg; // previous synchronised level

    // metastability chain, then one more flop for edge detection
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            last_reg <= 1'b0;
        end else begin
            meta_reg <= pin;
            sync_reg <= meta_reg;
            last_reg <= sync_reg;
        end
    end

    assign level = sync_reg;
    // either edge counts
    assign edge_pulse = sync_reg ^ last_reg;
endmodule
`default_nettype wire

// file: rtl/reload_counter.sv
// 12-bit up counter with reload on wrap, force-to-max and hold
`timescale 1ns/1ps
`default_nettype none
module reload_counter #(
    parameter int W = 12
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic run,
    input wire logic force_max,
    input wire logic [W-1:0] reload,
    output logic [W-1:0] count,
    output logic wrap
);
    logic [W-1:0] count_reg;

    // wrap when at maximum and allowed to step
    assign wrap = run && (count_reg == {W{1'b1}});

    // force wins over counting; hold while not running
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            count_reg <= '0;
        end else if (force_max) begin
            count_reg <= {W{1'b1}};
        end else if (wrap) begin
            count_reg <= reload;
        end else if (run) begin
            count_reg <= count_reg + 1'b1;
        end
    end

    assign count = count_reg;
endmodule
`default_nettype wire

// file: rtl/atimer_ctl.sv
// control and status block of the dual-counter auto-reload timer, APB slave
// Notes on behaviour
// - either capture pin edge copies first counter
// - capture only while capture flag clear
// - capture register read-only, resets to zero
// - second break enable gates upper pair while select set
// - first break enable gates lower, upper while select clear
// - second force bit loads maximum count
// - second force clears cycle after overflow
// - first force loads max, self-clears
// - source select picks normal or long pin
// - overflow irq only when enabled
// - overflow flag set on wrap
// - reading status register clears overflow flag
// - select routes upper pwm pair counter
// - second counter holds while select clear, except that a set second force bit still loads max
// - status register resets to 03
// - break enable resets 03, reserved bits
// - break forces pattern onto enabled outputs
// - duty transfer only when enabled
`timescale 1ns/1ps
`default_nettype none
module atimer_ctl
    import atimer_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // pins
    input wire logic normal_capture_pin,
    input wire logic long_capture_pin,
    input wire logic break_pin,
    // pwm datapath side
    input wire logic [3:0] pwm_raw,
    output logic [3:0] pwm_out,
    output logic upper_pair_counter_select,
    output logic duty_load1,
    output logic duty_load2,
    output logic second_overflow_irq,
    output logic [atimer_pkg::CNT_W-1:0] first_counter,
    output logic [atimer_pkg::CNT_W-1:0] second_counter
);
    import atimer_pkg::*;

    logic [7:0] ctl2_reg;                 // timer_ctl_status_second
    logic [BE_USED_W-1:0] break_en_reg;   // break_enable_ctl, used bits
    logic [7:0] break_ctl_reg;            // break_control
    logic [CNT_W-1:0] capture_reg;        // captured_count
    logic capture_flag_reg;               // capture_flag
    logic [CNT_W-1:0] reload2_reg;        // second_reload_value
    logic [3:0] out_en_reg;               // pwm_output_enable
    logic [31:0] prdata_reg;              // registered read data
    logic first_counter_force_overflow_clr_reg;                 // first overflow seen last cycle
    logic second_counter_force_overflow_clr_reg;                 // second overflow seen last cycle
    logic cap_n_edge, cap_l_edge, brk_level;
    logic cap_edge, wrap1, wrap2, wr_en, rd_en, addr_ok, break_active;
    logic [3:0] break_hit;

    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && penable && !pwrite;

    // pin synchronisers
    sync_edge u_sync_normal (
        .clk(clk), .nrst(nrst), .pin(normal_capture_pin),
        .level(), .edge_pulse(cap_n_edge)
    );
    sync_edge u_sync_long (
        .clk(clk), .nrst(nrst), .pin(long_capture_pin),
        .level(), .edge_pulse(cap_l_edge)
    );
    sync_edge u_sync_break (
        .clk(clk), .nrst(nrst), .pin(break_pin),
        .level(brk_level), .edge_pulse()
    );

    // counters: first runs always, second only while selected
    reload_counter #(.W(CNT_W)) u_cnt1 (
        .clk(clk), .nrst(nrst), .run(1'b1),
        // force only loads the maximum once: holding it through the wrap would stretch
        // the overflow and the duty transfer pulse to two cycles
        .force_max(ctl2_reg[CS_FIRST_COUNTER_FORCE_OVERFLOW] && !first_counter_force_overflow_clr_reg && !wrap1),
        .reload('0), .count(first_counter), .wrap(wrap1)
    );
    reload_counter #(.W(CNT_W)) u_cnt2 (
        .clk(clk), .nrst(nrst), .run(ctl2_reg[CS_SEL2]),
        .force_max(ctl2_reg[CS_SECOND_COUNTER_FORCE_OVERFLOW] && !second_counter_force_overflow_clr_reg && !wrap2),
        .reload(reload2_reg), .count(second_counter), .wrap(wrap2)
    );

    // capture source select
    assign cap_edge = ctl2_reg[CS_ICS] ? cap_l_edge : cap_n_edge;

    // capture register: loads only while flag clear, never written by software
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            capture_reg <= RST_CAPTURE;
        end else if (cap_edge && !capture_flag_reg) begin
            capture_reg <= first_counter;
        end
    end

    // capture flag: a software clear of a set flag wins over an edge in the same cycle
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            capture_flag_reg <= 1'b0;
        end else if (cap_edge && !capture_flag_reg) begin
            capture_flag_reg <= 1'b1;
        end else if (wr_en && paddr == OFS_CAPTURE_STATUS && pwdata[0]) begin
            capture_flag_reg <= 1'b0;
        end
    end

    // remember overflows so the force bit clears one cycle later
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            first_counter_force_overflow_clr_reg <= 1'b0;
            second_counter_force_overflow_clr_reg <= 1'b0;
        end else begin
            first_counter_force_overflow_clr_reg <= wrap1 && ctl2_reg[CS_FIRST_COUNTER_FORCE_OVERFLOW];
            second_counter_force_overflow_clr_reg <= wrap2 && ctl2_reg[CS_SECOND_COUNTER_FORCE_OVERFLOW];
        end
    end

    // second control/status register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctl2_reg <= RST_CTL_STATUS2;
        end else begin
            if (wr_en && paddr == OFS_CTL_STATUS2) begin
                // force bits can only be set by software
                ctl2_reg[CS_SECOND_COUNTER_FORCE_OVERFLOW] <= ctl2_reg[CS_SECOND_COUNTER_FORCE_OVERFLOW] | pwdata[CS_SECOND_COUNTER_FORCE_OVERFLOW];
                ctl2_reg[CS_FIRST_COUNTER_FORCE_OVERFLOW] <= ctl2_reg[CS_FIRST_COUNTER_FORCE_OVERFLOW] | pwdata[CS_FIRST_COUNTER_FORCE_OVERFLOW];
                ctl2_reg[CS_ICS] <= pwdata[CS_ICS];
                ctl2_reg[CS_SECOND_OVERFLOW_IRQ_EN] <= pwdata[CS_SECOND_OVERFLOW_IRQ_EN];
                ctl2_reg[CS_SEL2] <= pwdata[CS_SEL2];
                ctl2_reg[CS_SECOND_DUTY_TRANSFER_EN] <= pwdata[CS_SECOND_DUTY_TRANSFER_EN];
                ctl2_reg[CS_FIRST_DUTY_TRANSFER_EN] <= pwdata[CS_FIRST_DUTY_TRANSFER_EN];
            end
            if (first_counter_force_overflow_clr_reg) begin
                ctl2_reg[CS_FIRST_COUNTER_FORCE_OVERFLOW] <= 1'b0;
            end
            if (second_counter_force_overflow_clr_reg) begin
                ctl2_reg[CS_SECOND_COUNTER_FORCE_OVERFLOW] <= 1'b0;
            end
            // read clears the flag, a wrap in the same cycle keeps it set
            if (wrap2) begin
                ctl2_reg[CS_SECOND_OVERFLOW_FLAG] <= 1'b1;
            end else if (rd_en && paddr == OFS_CTL_STATUS2) begin
                ctl2_reg[CS_SECOND_OVERFLOW_FLAG] <= 1'b0;
            end
        end
    end

    // break enable, break control, reload value and output enables
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            break_en_reg <= RST_BREAK_EN[BE_USED_W-1:0];
            break_ctl_reg <= RST_BREAK_CTL;
            reload2_reg <= RST_RELOAD2;
            out_en_reg <= RST_OUT_EN;
        end else begin
            if (wr_en) begin
                unique case (paddr)
                    OFS_BREAK_EN: begin
                        break_en_reg <= pwdata[BE_USED_W-1:0]; // reserved bits dropped
                    end
                    OFS_BREAK_CTL: begin
                        break_ctl_reg <= pwdata[7:0];
                    end
                    OFS_RELOAD2: begin
                        reload2_reg <= pwdata[CNT_W-1:0];
                    end
                    OFS_OUT_EN: begin
                        out_en_reg <= pwdata[3:0];
                    end
                    default: begin
                    end
                endcase
            end
            // the pin raises break active; a set wins over a software clear
            if (brk_level) begin
                break_ctl_reg[BC_ACTIVE] <= 1'b1;
            end
        end
    end

    assign break_active = break_ctl_reg[BC_ACTIVE];

    // which outputs the break reaches
    always_comb begin
        break_hit[1:0] = {2{break_active && break_en_reg[BE_FIRST_COUNTER_BREAK_EN]}};
        if (ctl2_reg[CS_SEL2]) begin
            break_hit[3:2] = {2{break_active && break_en_reg[BE_SECOND_COUNTER_BREAK_EN]}};
        end else begin
            break_hit[3:2] = {2{break_active && break_en_reg[BE_FIRST_COUNTER_BREAK_EN]}};
        end
    end

    // force pattern only on enabled outputs
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            if (break_hit[i] && out_en_reg[i]) begin
                pwm_out[i] = break_ctl_reg[i];
            end else begin
                pwm_out[i] = pwm_raw[i];
            end
        end
    end

    // duty transfers on overflow events; upper pair follows its counter
    assign duty_load1 = wrap1 && ctl2_reg[CS_FIRST_DUTY_TRANSFER_EN];
    assign duty_load2 = (ctl2_reg[CS_SEL2] ? wrap2 : wrap1) && ctl2_reg[CS_SECOND_DUTY_TRANSFER_EN];
    assign upper_pair_counter_select = ctl2_reg[CS_SEL2];
    assign second_overflow_irq = ctl2_reg[CS_SECOND_OVERFLOW_FLAG] && ctl2_reg[CS_SECOND_OVERFLOW_IRQ_EN];

    // address decode
    always_comb begin
        unique case (paddr)
            OFS_CAPTURE_LOW, OFS_CAPTURE_HIGH, OFS_BREAK_EN, OFS_CTL_STATUS2,
            OFS_BREAK_CTL, OFS_CAPTURE_STATUS, OFS_RELOAD2, OFS_OUT_EN,
            OFS_COUNT1, OFS_COUNT2: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    end

    // read data captured in the setup cycle, stable through access
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            prdata_reg <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            unique case (paddr)
                OFS_CAPTURE_LOW: prdata_reg <= {24'h0, capture_reg[7:0]};
                OFS_CAPTURE_HIGH: prdata_reg <= {28'h0, capture_reg[11:8]};
                OFS_BREAK_EN: prdata_reg <= {30'h0, break_en_reg};
                OFS_CTL_STATUS2: prdata_reg <= {24'h0, ctl2_reg};
                OFS_BREAK_CTL: prdata_reg <= {24'h0, break_ctl_reg};
                OFS_CAPTURE_STATUS: prdata_reg <= {31'h0, capture_flag_reg};
                OFS_RELOAD2: prdata_reg <= {20'h0, reload2_reg};
                OFS_OUT_EN: prdata_reg <= {28'h0, out_en_reg};
                OFS_COUNT1: prdata_reg <= {20'h0, first_counter};
                OFS_COUNT2: prdata_reg <= {20'h0, second_counter};
                default: prdata_reg <= 32'h0000_0000;
            endcase
        end
    end

    assign prdata = prdata_reg;
    assign pready = 1'b1;                       // zero wait states
    assign pslverr = psel && penable && !addr_ok;
endmodule
`default_nettype wire

// file: dv/atimer_ctl_sva.sv
// checker: port-level rules of the timer control block
`timescale 1ns/1ps
`default_nettype none
module atimer_ctl_sva
    import atimer_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic upper_pair_counter_select,
    input wire logic duty_load1,
    input wire logic second_overflow_irq,
    input wire logic [atimer_pkg::CNT_W-1:0] first_counter,
    input wire logic [atimer_pkg::CNT_W-1:0] second_counter
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    // access phase qualifiers
    wire logic acc = psel && penable;
    wire logic rd = acc && !pwrite;
    a_no_wait: assert property (psel |-> pready) else $error("slave inserted wait");
    a_unmapped_err: assert property (acc && paddr > OFS_COUNT2 |-> pslverr)
        else $error("unmapped access not refused");
    a_mapped_ok: assert property (acc && paddr <= OFS_COUNT2 && paddr[1:0] == 2'b00 |-> !pslverr)
        else $error("mapped access refused");
    a_unmapped_zero: assert property (rd && paddr > OFS_COUNT2 |-> prdata == 32'h0)
        else $error("unmapped read not zero");
    a_cap_high_w: assert property (rd && paddr == OFS_CAPTURE_HIGH |-> prdata[31:4] == 28'h0)
        else $error("capture high wider than nibble");
    a_brk_rsvd: assert property (rd && paddr == OFS_BREAK_EN |-> prdata[31:2] == 30'h0)
        else $error("reserved break enable bits set");
    a_sel_write: assert property (acc && pwrite && paddr == OFS_CTL_STATUS2
        |=> upper_pair_counter_select == $past(pwdata[CS_SEL2]))
        else $error("select not taken from write");
    a_sel_read: assert property (rd && paddr == OFS_CTL_STATUS2
        |-> prdata[CS_SEL2] == upper_pair_counter_select) else $error("select readback");
    // the first cycle after select drops may still carry the last step
    a_cnt2_frozen: assert property (!upper_pair_counter_select && $past(!upper_pair_counter_select)
        |-> $stable(second_counter)) else $error("second counter moved while held");
    a_cnt1_step: assert property (first_counter == $past(first_counter) + 12'h001
        || first_counter == 12'h000 || first_counter == CNT_MAX)
        else $error("first counter jumped");
    a_cnt1_wrap: assert property (first_counter == CNT_MAX |=> first_counter == 12'h000)
        else $error("first counter did not reload zero");
    a_load_pulse: assert property (duty_load1 |=> !duty_load1)
        else $error("duty load longer than a cycle");
    c_load: cover property (duty_load1);
    c_irq: cover property (second_overflow_irq);
    c_err: cover property (acc && pslverr);
endmodule
bind atimer_ctl atimer_ctl_sva u_sva (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .upper_pair_counter_select(upper_pair_counter_select),
    .duty_load1(duty_load1), .second_overflow_irq(second_overflow_irq),
    .first_counter(first_counter), .second_counter(second_counter));
`default_nettype wire

// file: dv/pin_partner.sv
// partner: external capture and break pins
`timescale 1ns/1ps
`default_nettype none
module pin_partner (
    input wire logic clk,
    output logic normal_capture_pin,
    output logic long_capture_pin,
    output logic break_pin
);
    // pins idle low; each toggle is one edge for the capture logic
    initial begin
        normal_capture_pin = 1'b0;
        long_capture_pin = 1'b0;
        break_pin = 1'b0;
    end
    task automatic toggle(input logic lng);
        @(posedge clk);
        if (lng) long_capture_pin <= ~long_capture_pin;
        else normal_capture_pin <= ~normal_capture_pin;
    endtask
    task automatic set_break(input logic v);
        @(posedge clk);
        break_pin <= v;
    endtask
endmodule
`default_nettype wire

// file: dv/autoreload_timer_capture_break_tb_top.sv
// testbench: register, capture, force, overflow and break scenarios
`timescale 1ns/1ps
`default_nettype none
module autoreload_timer_capture_break_tb_top;
    import atimer_pkg::*;
    logic clk, nrst, psel, penable, pwrite, pready, pslverr, sel2, dl1, dl2, irq, serr, saw_a, saw_b;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q, old;
    logic [3:0] raw, pout;
    logic ncap, lcap, brk;
    logic [11:0] c1, c2, cyc, ref_cnt;
    int fail_count, n_tests;
    // break table: enable, select, output enable, expected pwm
    logic [15:0] tab [7] = '{16'h30f5, 16'h10f5, 16'h20fa, 16'h21f6, 16'h11f9, 16'h3039, 16'h00fa};
    atimer_ctl dut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .normal_capture_pin(ncap), .long_capture_pin(lcap), .break_pin(brk), .pwm_raw(raw),
        .pwm_out(pout), .upper_pair_counter_select(sel2), .duty_load1(dl1), .duty_load2(dl2),
        .second_overflow_irq(irq), .first_counter(c1), .second_counter(c2));
    pin_partner u_pins (.clk(clk), .normal_capture_pin(ncap), .long_capture_pin(lcap),
        .break_pin(brk));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // own count of cycles since release, reference for captured values
    always @(posedge clk) cyc <= nrst ? cyc + 12'h001 : 12'h000;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one apb transfer; request held until pready is seen high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        q = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic t_reset();
        apb(0, OFS_BREAK_EN, 0); check(q, 32'h3);
        apb(0, OFS_CTL_STATUS2, 0); check(q, 32'h3);
        apb(1, OFS_CAPTURE_LOW, 32'hff); apb(0, OFS_CAPTURE_LOW, 0); check(q, 32'h0);
        apb(1, OFS_BREAK_EN, 32'hfc); apb(0, OFS_BREAK_EN, 0); check(q, 32'h0);
        apb(0, 8'h40, 0); check({serr, q[30:0]}, 32'h80000000);
    endtask
    task automatic t_capture();
        ref_cnt = cyc;
        u_pins.toggle(0);
        repeat (6) @(posedge clk);
        apb(0, OFS_CAPTURE_LOW, 0); old = q;
        apb(0, OFS_CAPTURE_HIGH, 0);
        check(12'({q[3:0], old[7:0]} - ref_cnt) <= 12'd8, 1);
        apb(0, OFS_CAPTURE_STATUS, 0); check(q[0], 1);
        u_pins.toggle(0);
        repeat (6) @(posedge clk);
        apb(0, OFS_CAPTURE_LOW, 0); check(q, old);
        apb(1, OFS_CAPTURE_STATUS, 1); apb(0, OFS_CAPTURE_STATUS, 0); check(q[0], 0);
        u_pins.toggle(1); // long pin not selected yet
        repeat (6) @(posedge clk);
        apb(0, OFS_CAPTURE_STATUS, 0); check(q[0], 0);
        apb(1, OFS_CTL_STATUS2, 32'h23);
        u_pins.toggle(1);
        repeat (6) @(posedge clk);
        apb(0, OFS_CAPTURE_STATUS, 0); check(q[0], 1);
        apb(1, OFS_CAPTURE_STATUS, 1);
    endtask
    // force first counter, with and without duty transfer
    task automatic t_first_counter_force_overflow(input logic tr);
        saw_a = 0;
        saw_b = 0;
        apb(1, OFS_CTL_STATUS2, {24'h0, 8'h42 | 8'(tr)});
        repeat (8) @(negedge clk) begin
            if (c1 === CNT_MAX) saw_a = 1;
            if (dl1 === 1'b1) saw_b = 1;
        end
        check(saw_a, 1);
        check(saw_b, tr);
        apb(0, OFS_CTL_STATUS2, 0); check(q[7:6], 0);
    endtask
    // force second counter; overflow flag, irq gating and clear on read
    task automatic t_second_counter_force_overflow(input logic ie);
        saw_a = 0;
        saw_b = 0;
        apb(1, OFS_CTL_STATUS2, {24'h0, 8'h87 | {3'h0, ie, 4'h0}});
        repeat (8) @(negedge clk) begin
            if (c2 === CNT_MAX) saw_a = 1;
            if (dl2 === 1'b1) saw_b = 1;
        end
        check(saw_a, 1);
        check(saw_b, 1);
        check(irq, ie);
        apb(0, OFS_CTL_STATUS2, 0); check(q[7:3], {3'h0, ie, 1'b1});
        @(negedge clk); check(irq, 0);
        apb(0, OFS_CTL_STATUS2, 0); check(q[3], 0);
    endtask
    task automatic t_break();
        apb(1, OFS_BREAK_CTL, 32'h25);
        foreach (tab[i]) begin
            apb(1, OFS_BREAK_EN, 32'(tab[i][15:12]));
            apb(1, OFS_CTL_STATUS2, {29'h0, tab[i][8], 2'b11});
            apb(1, OFS_OUT_EN, 32'(tab[i][7:4]));
            @(negedge clk); check(pout, tab[i][3:0]);
            check(sel2, tab[i][8]);
        end
        apb(1, OFS_BREAK_CTL, 32'h05);
        raw <= 4'h6; // break off: outputs follow the datapath
        @(negedge clk); check(pout, 4'h6);
        u_pins.set_break(1);
        repeat (6) @(posedge clk);
        apb(0, OFS_BREAK_CTL, 0); check(q[5], 1);
        u_pins.set_break(0);
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        {nrst, psel, penable, pwrite, paddr, pwdata, fail_count, n_tests} = '0;
        raw = 4'ha;
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        t_reset();
        t_capture();
        t_first_counter_force_overflow(1);
        t_first_counter_force_overflow(0);
        apb(1, OFS_RELOAD2, 32'h123);
        t_second_counter_force_overflow(1);
        t_second_counter_force_overflow(0);
        apb(1, OFS_CTL_STATUS2, 32'h03); // counter two held from here
        repeat (20) @(posedge clk);
        apb(0, OFS_COUNT2, 0);
        old = q;
        repeat (4) @(posedge clk);
        apb(0, OFS_COUNT2, 0);
        check(q, old);
        t_break();
        conclude();
    end
    // watchdog: the whole run needs well under a thousand cycles
    initial begin
        #100000;
        fail_count++;
        conclude();
    end
endmodule
`default_nettype wire
